// [src/cfg_loader_params.svh]
// Addresses, bit positions and reset values of the configuration loader
`ifndef CFG_LOADER_PARAMS_SVH
`define CFG_LOADER_PARAMS_SVH
`define CFG_ADDR_A 16'hfb00
`define CFG_ADDR_B 16'hfb01
`define WDT_CK_BIT 7
`define BOV_HI_BIT 6
`define BOV_LO_BIT 5
`define FILTER_BIT 2
`define OSC_HI_BIT 1
`define OSC_LO_BIT 0
`define RC_FS_BIT 5
`define CFG_BYTE_RST 8'hff
`define LINK_HDR_BITS 2
`define LINK_DATA_BITS 8
`define RELEASE_MAX_CYCLES 4
`endif

// [src/cfg_loader_pkg.sv]
// Types shared by the configuration loader files
package cfg_loader_pkg;
	typedef enum logic [1:0] {
		OSC_CRYSTAL = 2'h0,
		OSC_INT_RC = 2'h1,
		OSC_RESERVED = 2'h2,
		OSC_EXT_CLK = 2'h3
	} osc_type_e;
	typedef enum logic [1:0] {
		BOV_4V5 = 2'h0,
		BOV_3V8 = 2'h1,
		BOV_2V7 = 2'h2,
		BOV_2V4 = 2'h3
	} bov_trip_e;
	typedef enum logic [3:0] {
		ST_ISSUE_A = 4'h1,
		ST_TAKE_A = 4'h2,
		ST_TAKE_B = 4'h4,
		ST_IDLE = 4'h8
	} load_state_e;
	typedef struct packed {
		logic sel;
		logic [7:0] data;
	} link_write_s;
	typedef struct packed {
		logic [7:0] byte_b;
		logic [7:0] byte_a;
	} cfg_pair_s;
	typedef struct packed {
		logic watchdog_clock_select;
		logic [1:0] brownout_level;
		bov_trip_e bov_trip;
		logic clock_filter_control;
		osc_type_e osc_type;
		logic xtal_pins_as_port;
		logic crystal_pin_out_hiz;
		logic rc_frequency_select;
	} cfg_decoded_s;
endpackage

// [src/cfg_store.sv]
// Non-volatile configuration byte storage with registered read
`timescale 1ns/1ns
module cfg_store #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2,
	parameter int AW = 1
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic we_in,
	input wire logic [AW-1:0] waddr_in,
	input wire logic [WIDTH-1:0] wdata_in,
	input wire logic [AW-1:0] raddr_in,
	output logic [WIDTH-1:0] rdata_out
);
	// Erased cells read all ones
	logic [WIDTH-1:0] mem [DEPTH] = '{default: {WIDTH{1'b1}}};

	generate
		if (DEPTH != (1 << AW)) begin : g_bad
			$error("cfg_store: DEPTH must equal 2**AW");
		end
	endgenerate

	// Contents survive reset
	always_ff @(posedge mclk_in) begin
		if (we_in) begin
			mem[waddr_in] <= wdata_in;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			rdata_out <= '0;
		end else begin
			rdata_out <= mem[raddr_in];
		end
	end
endmodule

// [src/icp_link.sv]
// Serial programming link shifter on the programming clock
`timescale 1ns/1ns
`include "cfg_loader_params.svh"
module icp_link #(
	parameter int DATA_BITS = `LINK_DATA_BITS
) (
	input wire logic prog_clk_in,
	input wire logic mode_pin_in,
	input wire logic data_pin_in,
	input cfg_loader_pkg::cfg_pair_s snap_in,
	input wire logic snap_tgl_in,
	output logic data_pin_out,
	output logic data_pin_oe_n_out,
	output cfg_loader_pkg::link_write_s wr_out,
	output logic wr_tgl_out
);
	localparam int FRAME = `LINK_HDR_BITS + DATA_BITS;
	localparam int CW = $clog2(FRAME);
	localparam logic [CW-1:0] LAST = CW'(FRAME - 1);
	localparam logic [CW-1:0] HDR = CW'(`LINK_HDR_BITS);

	logic mode_s1, mode_s2;
	logic snap_s1, snap_s2, snap_s3;
	cfg_loader_pkg::cfg_pair_s snap_reg;
	logic [CW-1:0] cnt_reg;
	logic op_reg, sel_reg;
	logic [DATA_BITS-1:0] shift_reg, rd_reg;
	logic wr_tgl_reg = 1'b0;

	generate
		if (DATA_BITS != 8 || `LINK_HDR_BITS != 2) begin : g_bad
			$error("icp_link: frame must be 2 header and 8 data bits");
		end
	endgenerate

	// Mode pin synchroniser; low ends any frame
	always_ff @(posedge prog_clk_in) begin
		mode_s1 <= mode_pin_in;
		mode_s2 <= mode_s1;
	end

	// Snapshot words taken on synced toggle
	always_ff @(posedge prog_clk_in) begin
		snap_s1 <= snap_tgl_in;
		snap_s2 <= snap_s1;
		snap_s3 <= snap_s2;
		if (!mode_s2 || snap_s2 != snap_s3) begin
			snap_reg <= snap_in;
		end
	end

	// [RULE13] Bit counter per clock
	always_ff @(posedge prog_clk_in) begin
		if (!mode_s2 || cnt_reg == LAST) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// [RULE13] Header and data sampling
	always_ff @(posedge prog_clk_in) begin
		if (mode_s2 && cnt_reg == '0) begin
			op_reg <= data_pin_in;
		end
		if (mode_s2 && cnt_reg == 1) begin
			sel_reg <= data_pin_in;
		end
		if (mode_s2 && cnt_reg >= HDR) begin
			shift_reg <= {shift_reg[DATA_BITS-2:0], data_pin_in};
		end
	end

	// [RULE3] Written byte handed over; toggle never cleared
	always_ff @(posedge prog_clk_in) begin
		if (mode_s2 && cnt_reg == LAST && op_reg) begin
			wr_out.sel <= sel_reg;
			wr_out.data <= {shift_reg[DATA_BITS-2:0], data_pin_in};
			wr_tgl_reg <= ~wr_tgl_reg;
		end
	end

	assign wr_tgl_out = wr_tgl_reg;

	// [RULE11] Data pin driven on reads
	always_ff @(posedge prog_clk_in) begin
		if (!mode_s2) begin
			data_pin_oe_n_out <= 1'b1;
			rd_reg <= '0;
		end else if (cnt_reg == 1 && !op_reg) begin
			rd_reg <= data_pin_in ? snap_reg.byte_b : snap_reg.byte_a;
			data_pin_oe_n_out <= 1'b0;
		end else if (cnt_reg == LAST) begin
			data_pin_oe_n_out <= 1'b1;
		end else begin
			rd_reg <= {rd_reg[DATA_BITS-2:0], 1'b0};
		end
	end

	assign data_pin_out = rd_reg[DATA_BITS-1];
endmodule

// [src/config_byte_loader.sv]
// Boot configuration loader with in-circuit programming path
`timescale 1ns/1ns
`include "cfg_loader_params.svh"
// How it works
// [RULE1] Two config bytes stored at fb00 and fb01.
// [RULE2] Settings fixed at boot; program cannot change them later.
// [RULE3] Bytes may be programmed and read back any number of times.
// [RULE4] Byte a bit 7: 0 internal 500KHz RC, 1 CPU clock for watchdog.
// [RULE5] Brownout level bits load inverse of byte a bits 6 and 5.
// [RULE6] Brownout pair 11 2.4V, 10 2.7V, 01 3.8V, 00 4.5V.
// [RULE7] Byte a bit 2: 0 clock filter off, 1 on.
// [RULE8] Oscillator bits 00: crystal 4 to 24MHz.
// [RULE9] Oscillator bits 01: internal RC, crystal pins become port pins.
// [RULE10] Oscillator 11: external clock on first pin, second pin floats.
// [RULE11] Programming uses three pins: mode, clock, two-way data.
// [RULE12] Tool holds mode pin high for the whole session.
// [RULE13] Data shifts in step with the tool's serial clock.
// [RULE14] Tool should erase and program config bytes in one go.
// [RULE15] Byte b bit 5: 1 selects 22MHz RC, 0 selects 11MHz.
// [RULE16] Bytes latched before CPU release, held until next reset.
module config_byte_loader #(
	parameter int LINK_DATA_BITS = `LINK_DATA_BITS
) (
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	input wire logic prog_clock_pin_in,
	input wire logic icp_mode_in,
	input wire logic prog_data_pin_in,
	output logic prog_data_pin_out,
	output logic prog_data_pin_oe_n_out,
	output logic cpu_release_out,
	output logic [7:0] boot_option_byte_a_out,
	output logic [7:0] boot_option_byte_b_out,
	output cfg_loader_pkg::cfg_decoded_s settings_out
);
	localparam logic [15:0] ADDR_A = `CFG_ADDR_A;
	localparam logic [15:0] ADDR_B = `CFG_ADDR_B;

	cfg_loader_pkg::load_state_e state_reg, state_next;
	cfg_loader_pkg::link_write_s link_wr, wr_hold_reg;
	cfg_loader_pkg::cfg_pair_s snap_reg;
	cfg_loader_pkg::cfg_decoded_s settings_reg;
	logic link_wr_tgl;
	logic snap_tgl_reg;
	logic mode_s1, mode_s2, mode_s3;
	logic wr_s1, wr_s2, wr_s3;
	logic wr_event, pend_reg, boot_reg, release_reg;
	logic [7:0] byte_a_reg, byte_b_reg, mem_rdata;
	logic mem_we;
	logic mem_waddr, mem_raddr;

	generate
		if (LINK_DATA_BITS != 8) begin : g_bad
			$error("config_byte_loader: bytes are 8 bits wide");
		end
	endgenerate

	// Storage index of a config address
	function automatic logic addr_index(input logic [15:0] addr);
		return addr[0];
	endfunction

	// Byte pair to decoded settings
	function automatic cfg_loader_pkg::cfg_decoded_s decode(
		input logic [7:0] a,
		input logic [7:0] b
	);
		cfg_loader_pkg::cfg_decoded_s d;
		cfg_loader_pkg::osc_type_e osc;
		osc = cfg_loader_pkg::osc_type_e'({a[`OSC_HI_BIT], a[`OSC_LO_BIT]});
		// [RULE4] Watchdog clock source
		d.watchdog_clock_select = a[`WDT_CK_BIT];
		// [RULE5] Inverted brownout pair
		d.brownout_level = ~{a[`BOV_HI_BIT], a[`BOV_LO_BIT]};
		// [RULE6] Brownout trip level
		d.bov_trip =
			cfg_loader_pkg::bov_trip_e'({a[`BOV_HI_BIT], a[`BOV_LO_BIT]});
		// [RULE7] Clock filter enable
		d.clock_filter_control = a[`FILTER_BIT];
		// [RULE8] Oscillator type, crystal at 00
		d.osc_type = osc;
		// [RULE9] RC frees crystal pins
		d.xtal_pins_as_port = (osc == cfg_loader_pkg::OSC_INT_RC);
		// [RULE10] External clock floats second pin
		d.crystal_pin_out_hiz = (osc == cfg_loader_pkg::OSC_EXT_CLK);
		// [RULE15] RC frequency select
		d.rc_frequency_select = b[`RC_FS_BIT];
		return d;
	endfunction

	// [RULE11] Three-pin programming link
	icp_link #(
		.DATA_BITS(LINK_DATA_BITS)
	) u_link (
		.prog_clk_in(prog_clock_pin_in),
		.mode_pin_in(icp_mode_in),
		.data_pin_in(prog_data_pin_in),
		.snap_in(snap_reg),
		.snap_tgl_in(snap_tgl_reg),
		.data_pin_out(prog_data_pin_out),
		.data_pin_oe_n_out(prog_data_pin_oe_n_out),
		.wr_out(link_wr),
		.wr_tgl_out(link_wr_tgl)
	);

	// [RULE1] Config byte storage
	cfg_store #(
		.WIDTH(8),
		.DEPTH(2),
		.AW(1)
	) u_store (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.we_in(mem_we),
		.waddr_in(mem_waddr),
		.wdata_in(wr_hold_reg.data),
		.raddr_in(mem_raddr),
		.rdata_out(mem_rdata)
	);

	// Mode and write toggle synchronisers
	always_ff @(posedge mclk_in) begin
		mode_s1 <= icp_mode_in;
		mode_s2 <= mode_s1;
		mode_s3 <= mode_s2;
		wr_s1 <= link_wr_tgl;
		wr_s2 <= wr_s1;
		wr_s3 <= wr_s2;
	end

	// [RULE12] Writes only while session held
	assign wr_event = mode_s2 && mode_s3 && (wr_s2 != wr_s3);

	// Captured link word, stable past toggle
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			wr_hold_reg <= '0;
		end else if (wr_event) begin
			wr_hold_reg <= link_wr;
		end
	end

	// Pending write; new event wins over clear
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			pend_reg <= 1'b0;
		end else if (wr_event) begin
			pend_reg <= 1'b1;
		end else if (state_reg == cfg_loader_pkg::ST_IDLE) begin
			pend_reg <= 1'b0;
		end
	end

	// [RULE3] Repeated programming
	assign mem_we = (state_reg == cfg_loader_pkg::ST_IDLE) && pend_reg
		&& !wr_event;
	assign mem_waddr = wr_hold_reg.sel ? addr_index(ADDR_B)
		: addr_index(ADDR_A);
	assign mem_raddr = (state_reg == cfg_loader_pkg::ST_ISSUE_A)
		? addr_index(ADDR_A) : addr_index(ADDR_B);

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			cfg_loader_pkg::ST_ISSUE_A: begin
				state_next = cfg_loader_pkg::ST_TAKE_A;
			end
			cfg_loader_pkg::ST_TAKE_A: begin
				state_next = cfg_loader_pkg::ST_TAKE_B;
			end
			cfg_loader_pkg::ST_TAKE_B: begin
				state_next = cfg_loader_pkg::ST_IDLE;
			end
			cfg_loader_pkg::ST_IDLE: begin
				if (mem_we) begin
					state_next = cfg_loader_pkg::ST_ISSUE_A;
				end
			end
			default: begin
				state_next = cfg_loader_pkg::ST_ISSUE_A;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			state_reg <= cfg_loader_pkg::ST_ISSUE_A;
		end else begin
			state_reg <= state_next;
		end
	end

	// Readback mirror for the link
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			snap_reg <= '0;
			snap_tgl_reg <= 1'b0;
		end else if (state_reg == cfg_loader_pkg::ST_TAKE_A) begin
			snap_reg.byte_a <= mem_rdata;
		end else if (state_reg == cfg_loader_pkg::ST_TAKE_B) begin
			snap_reg.byte_b <= mem_rdata;
			snap_tgl_reg <= ~snap_tgl_reg;
		end
	end

	// [RULE16] Boot latch, held until reset
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			boot_reg <= 1'b1;
			release_reg <= 1'b0;
			byte_a_reg <= `CFG_BYTE_RST;
			byte_b_reg <= `CFG_BYTE_RST;
		end else if (boot_reg) begin
			if (state_reg == cfg_loader_pkg::ST_TAKE_A) begin
				byte_a_reg <= mem_rdata;
			end
			if (state_reg == cfg_loader_pkg::ST_TAKE_B) begin
				byte_b_reg <= mem_rdata;
				boot_reg <= 1'b0;
				release_reg <= 1'b1;
			end
		end
	end

	// [RULE2] Decode only at boot
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			settings_reg <= decode(`CFG_BYTE_RST, `CFG_BYTE_RST);
		end else if (boot_reg && state_reg == cfg_loader_pkg::ST_TAKE_B) begin
			settings_reg <= decode(byte_a_reg, mem_rdata);
		end
	end

	assign cpu_release_out = release_reg;
	assign boot_option_byte_a_out = byte_a_reg;
	assign boot_option_byte_b_out = byte_b_reg;
	assign settings_out = settings_reg;

	property p_release_sticky;
		@(posedge mclk_in) disable iff (sys_rst_in)
		release_reg |=> release_reg;
	endproperty
	a_release_sticky: assert property (p_release_sticky) // [RULE16]
		else $error("CPU release dropped without reset");

	property p_release_time;
		@(posedge mclk_in)
		(!sys_rst_in && $past(sys_rst_in)) |-> ##[1:4] release_reg;
	endproperty
	a_release_time: assert property (p_release_time) // [RULE16]
		else $error("CPU not released after reset");

	property p_latched_stable;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(release_reg && $past(release_reg)) |->
			$stable(byte_a_reg) && $stable(byte_b_reg)
			&& $stable(settings_reg);
	endproperty
	a_latched_stable: assert property (p_latched_stable) // [RULE2]
		else $error("Latched configuration changed while running");

	property p_wdt_sel;
		@(posedge mclk_in) disable iff (sys_rst_in)
		release_reg |->
			settings_reg.watchdog_clock_select == byte_a_reg[`WDT_CK_BIT];
	endproperty
	a_wdt_sel: assert property (p_wdt_sel) // [RULE4]
		else $error("Watchdog clock select wrong");

	property p_bov_inverse;
		@(posedge mclk_in) disable iff (sys_rst_in)
		release_reg |-> settings_reg.brownout_level
			== ~byte_a_reg[`BOV_HI_BIT:`BOV_LO_BIT];
	endproperty
	a_bov_inverse: assert property (p_bov_inverse) // [RULE5]
		else $error("Brownout level not inverse of config");

	property p_bov_trip;
		@(posedge mclk_in) disable iff (sys_rst_in)
		release_reg && byte_a_reg[`BOV_HI_BIT:`BOV_LO_BIT] == 2'h2 |->
			settings_reg.bov_trip == cfg_loader_pkg::BOV_2V7;
	endproperty
	a_bov_trip: assert property (p_bov_trip) // [RULE6]
		else $error("Brownout trip decode wrong");

	property p_filter;
		@(posedge mclk_in) disable iff (sys_rst_in)
		release_reg |->
			settings_reg.clock_filter_control == byte_a_reg[`FILTER_BIT];
	endproperty
	a_filter: assert property (p_filter) // [RULE7]
		else $error("Clock filter setting wrong");

	property p_osc_pins;
		@(posedge mclk_in) disable iff (sys_rst_in)
		release_reg |-> (settings_reg.xtal_pins_as_port
			== (byte_a_reg[`OSC_HI_BIT:`OSC_LO_BIT] == 2'h1))
			&& (settings_reg.crystal_pin_out_hiz
			== (byte_a_reg[`OSC_HI_BIT:`OSC_LO_BIT] == 2'h3));
	endproperty
	a_osc_pins: assert property (p_osc_pins) // [RULE9]
		else $error("Crystal pin use wrong for oscillator type");

	property p_rc_freq;
		@(posedge mclk_in) disable iff (sys_rst_in)
		release_reg |->
			settings_reg.rc_frequency_select == byte_b_reg[`RC_FS_BIT];
	endproperty
	a_rc_freq: assert property (p_rc_freq) // [RULE15]
		else $error("RC frequency select wrong");

	property p_write_refresh;
		@(posedge mclk_in) disable iff (sys_rst_in)
		mem_we |=> state_reg == cfg_loader_pkg::ST_ISSUE_A ##3
			$changed(snap_tgl_reg);
	endproperty
	a_write_refresh: assert property (p_write_refresh) // [RULE3]
		else $error("Readback not refreshed after write");
endmodule

// [verification/prog_tool_model.sv]
// Programming tool model driving the serial configuration link
`timescale 1ns/1ns
module prog_tool_model (
	output logic pclk_out,
	output logic mode_out,
	output logic data_out,
	input wire logic dev_data_in,
	input wire logic dev_oe_n_in
);
	logic tool_val;
	logic tool_en;
	assign data_out = !dev_oe_n_in ? dev_data_in : (tool_en ? tool_val : 1'b1);
	initial begin
		pclk_out = 1'b0;
		mode_out = 1'b0;
		tool_en = 1'b0;
		tool_val = 1'b0;
	end
	task automatic pulse(output logic smp);
		#6 pclk_out = 1'b1;
		#6 smp = data_out;
		pclk_out = 1'b0;
	endtask
	// Clears link state with mode low
	task automatic idle_clear();
		logic smp;
		mode_out = 1'b0;
		tool_en = 1'b0;
		pulse(smp);
		pulse(smp);
	endtask
	// Bits msb first, changed off falling
	task automatic frame(input logic md, input logic wr, input logic sel,
		input logic [7:0] wd, output logic [7:0] rd);
		logic smp;
		logic [9:0] bits;
		bits = {wr, sel, wd};
		rd = 8'h00;
		mode_out = md;
		tool_en = 1'b1;
		tool_val = 1'b1;
		pulse(smp);
		pulse(smp);
		for (int i = 9; i >= 0; i--) begin
			tool_val = bits[i];
			tool_en = wr || i >= 8;
			pulse(smp);
			if (i >= 1 && i <= 8) begin
				rd[i - 1] = smp;
			end
		end
		// Mode kept while the write crosses
		#400;
		idle_clear();
	endtask
	// Both bytes programmed in one run
	task automatic write_pair(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] junk;
		frame(1'b1, 1'b1, 1'b0, a, junk);
		#1000;
		frame(1'b1, 1'b1, 1'b1, b, junk);
	endtask
endmodule

// [verification/tb_config_byte_loader.sv]
// Testbench for the boot configuration loader
`timescale 1ns/1ns
`include "cfg_loader_params.svh"
module tb_config_byte_loader;
	logic mclk_in;
	logic sys_rst_in;
	logic pclk;
	logic mode;
	logic pdata;
	logic dev_do;
	logic dev_oe_n;
	logic rel;
	logic [7:0] byte_a;
	logic [7:0] byte_b;
	cfg_loader_pkg::cfg_decoded_s st;
	logic [7:0] pa;
	logic [7:0] pb;
	logic have_prev;
	int miscompares = 0;
	int n_tests = 0;
	config_byte_loader dut_u (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.prog_clock_pin_in(pclk),
		.icp_mode_in(mode),
		.prog_data_pin_in(pdata),
		.prog_data_pin_out(dev_do),
		.prog_data_pin_oe_n_out(dev_oe_n),
		.cpu_release_out(rel),
		.boot_option_byte_a_out(byte_a),
		.boot_option_byte_b_out(byte_b),
		.settings_out(st)
	);
	prog_tool_model tool_u (
		.pclk_out(pclk),
		.mode_out(mode),
		.data_out(pdata),
		.dev_data_in(dev_do),
		.dev_oe_n_in(dev_oe_n)
	);
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("Checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Decoded settings against the stored bytes
	task automatic check_decode(input logic [7:0] a, input logic [7:0] b);
		cfg_loader_pkg::bov_trip_e trip;
		case (a[6:5])
			2'h3: trip = cfg_loader_pkg::BOV_2V4;
			2'h2: trip = cfg_loader_pkg::BOV_2V7;
			2'h1: trip = cfg_loader_pkg::BOV_3V8;
			default: trip = cfg_loader_pkg::BOV_4V5;
		endcase
		check("byte a", byte_a, a);
		check("byte b", byte_b, b);
		check("wdt clock", st.watchdog_clock_select, a[7]);
		check("bov level", st.brownout_level, 2'(~a[6:5]));
		check("bov trip", st.bov_trip, trip);
		check("filter", st.clock_filter_control, a[2]);
		check("osc type", st.osc_type, a[1:0]);
		check("xtal port", st.xtal_pins_as_port, a[1:0] == 2'h1);
		check("xt2 hiz", st.crystal_pin_out_hiz, a[1:0] == 2'h3);
		check("rc freq", st.rc_frequency_select, b[5]);
	endtask
	// Reset pulse, release timing, then decode
	task automatic reboot(input logic [7:0] a, input logic [7:0] b);
		int n;
		@(negedge mclk_in);
		sys_rst_in = 1'b1;
		@(negedge mclk_in);
		check("release in reset", rel, 1'b0);
		check("byte a in reset", byte_a, `CFG_BYTE_RST);
		sys_rst_in = 1'b0;
		n = 0;
		while (rel !== 1'b1 && n < 8) begin
			@(negedge mclk_in);
			n++;
		end
		check("release cycles", n <= `RELEASE_MAX_CYCLES, 1'b1);
		check_decode(a, b);
	endtask
	// Program, read back, refuse modeless write, hold, reboot
	task automatic boot_case(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] rd;
		tool_u.write_pair(a, b);
		#1000;
		tool_u.frame(1'b1, 1'b0, 1'b0, 8'h00, rd);
		check("readback a", rd, a);
		tool_u.frame(1'b1, 1'b0, 1'b1, 8'h00, rd);
		check("readback b", rd, b);
		tool_u.frame(1'b0, 1'b1, 1'b0, ~a, rd);
		#1000;
		tool_u.frame(1'b1, 1'b0, 1'b0, 8'h00, rd);
		check("modeless write", rd, a);
		check("oe_n idle", dev_oe_n, 1'b1);
		if (have_prev) begin
			check("release held", rel, 1'b1);
			check_decode(pa, pb);
		end
		reboot(a, b);
		pa = a;
		pb = b;
		have_prev = 1'b1;
	endtask
	initial begin
		sys_rst_in = 1'b1;
		have_prev = 1'b0;
		pa = 8'h00;
		pb = 8'h00;
		repeat (3) @(negedge mclk_in);
		sys_rst_in = 1'b0;
		tool_u.idle_clear();
		boot_case(8'h00, 8'h20);
		boot_case(8'he5, 8'h00);
		boot_case(8'h46, 8'hdf);
		boot_case(8'ha3, 8'hff);
		end_sim();
	end
	initial begin
		#200000;
		miscompares++;
		end_sim();
	end
endmodule
